// *** logic/mpwm_ctrl.sv ***
/*
 Meter PWM control registers, prescaler, shared 8-bit counter and four channels.
 Assumes an 8-bit register access port and port latch values on the mclk domain.
*/
`timescale 1ns/1ps
module mpwm_ctrl
    import mpwm_pkg::*;
#(
    parameter int DIV_A_LOG2 = MPWM_DIV_A_LOG2,
    parameter int DIV_B_LOG2 = MPWM_DIV_B_LOG2
)
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire mpwm_req_t bus,
    input wire logic [MPWM_METERS-1:0][3:0] port_val,
    output logic [7:0] rdata,
    output logic [MPWM_METERS-1:0][3:0] meter_pins
);

    mpwm_top_state_t s_q;
    mpwm_top_state_t s_d;
    logic tick;
    logic ovf;
    logic [MPWM_METERS-1:0] ten;
    logic [MPWM_METERS-1:0] cmpc_hit;
    logic [7:0] cnt_now;
    logic [7:0] wdata_now;

    // Prescaled clock choice
    assign tick = s_q.clksel ? &s_q.pre[DIV_B_LOG2-1:0] : &s_q.pre[DIV_A_LOG2-1:0]; // R7
    assign ovf = s_q.run && tick && (s_q.cnt == MPWM_CNT_TOP);
    assign cnt_now = s_q.cnt;
    assign wdata_now = bus.wdata;

    always_comb begin
        for (int m = 0; m < MPWM_METERS; m++) begin
            ten[m] = s_q.cmpc[m][MPWM_CMP_TEN_BIT];
            cmpc_hit[m] = bus.wr && (bus.addr == MPWM_ADDR_CMP_CTRL + 16'(m)); // R9
        end
    end

    always_comb begin
        logic [7:0] rd_byte;
        rd_byte = 8'h00;
        s_d = s_q;
        s_d.pre = s_q.pre + 8'h01;

        // Shared counter: 00 on start, then 01..FF repeating
        if (!s_q.run) begin
            s_d.cnt = 8'h00; // R3
        end else if (tick) begin
            s_d.cnt = (s_q.cnt == MPWM_CNT_TOP) ? MPWM_CNT_WRAP : s_q.cnt + 8'h01; // R6
        end

        // Pending transfer retires at overflow; a same-cycle write wins
        for (int m = 0; m < MPWM_METERS; m++) begin
            if (ovf && ten[m]) begin
                s_d.cmpc[m][MPWM_CMP_TEN_BIT] = 1'b0; // R12
            end
        end

        if (bus.wr) begin
            if (bus.addr == MPWM_ADDR_CNT_CTRL) begin
                s_d.run = bus.wdata[MPWM_CC_RUN_BIT]; // R1
                s_d.clksel = bus.wdata[MPWM_CC_CLKSEL_BIT]; // R6
            end
            if (bus.addr == MPWM_ADDR_PORT_MODE) begin
                s_d.meter_port_mode = bus.wdata; // R21
            end
            for (int m = 0; m < MPWM_METERS; m++) begin
                if (cmpc_hit[m]) begin
                    s_d.cmpc[m] = bus.wdata[MPWM_CMP_WIDTH-1:0]; // R8
                end
                if (bus.addr == MPWM_ADDR_CMP_VALUE + 16'(2 * m)) begin
                    s_d.hold_sin[m] = bus.wdata;
                end
                if (bus.addr == MPWM_ADDR_CMP_VALUE + 16'(2 * m + 1)) begin
                    s_d.hold_cos[m] = bus.wdata;
                end
            end
        end

        // Undefined bits are not stored and read as zero
        if (bus.rd) begin
            if (bus.addr == MPWM_ADDR_CNT_CTRL) begin
                rd_byte[MPWM_CC_RUN_BIT] = s_q.run; // R5
                rd_byte[MPWM_CC_CLKSEL_BIT] = s_q.clksel;
            end
            if (bus.addr == MPWM_ADDR_CNT_VALUE) begin
                rd_byte = s_q.cnt;
            end
            if (bus.addr == MPWM_ADDR_PORT_MODE) begin
                rd_byte = s_q.meter_port_mode; // R17
            end
            for (int m = 0; m < MPWM_METERS; m++) begin
                if (bus.addr == MPWM_ADDR_CMP_CTRL + 16'(m)) begin
                    rd_byte = {3'b000, s_q.cmpc[m]}; // R14
                end
                if (bus.addr == MPWM_ADDR_CMP_VALUE + 16'(2 * m)) begin
                    rd_byte = s_q.hold_sin[m];
                end
                if (bus.addr == MPWM_ADDR_CMP_VALUE + 16'(2 * m + 1)) begin
                    rd_byte = s_q.hold_cos[m];
                end
            end
        end
        s_d.rdata = rd_byte;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.run <= MPWM_CNT_CTRL_RST[MPWM_CC_RUN_BIT]; // R2
            s_q.clksel <= MPWM_CNT_CTRL_RST[MPWM_CC_CLKSEL_BIT]; // R2
            s_q.cmpc <= {MPWM_METERS{MPWM_CMP_CTRL_RST}}; // R10
            s_q.hold_sin <= {MPWM_METERS{MPWM_CMP_VALUE_RST}};
            s_q.hold_cos <= {MPWM_METERS{MPWM_CMP_VALUE_RST}};
            s_q.meter_port_mode <= MPWM_PORT_MODE_RST; // R18
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata = s_q.rdata;

    for (genvar m = 0; m < MPWM_METERS; m++) begin : g_meter
        mpwm_meter_cfg_t cfg;
        assign cfg = {s_q.meter_port_mode[MPWM_PM_EN_LSB + m],
                      s_q.meter_port_mode[MPWM_PM_HALF_LSB + m],
                      s_q.cmpc[m][MPWM_CMP_ADD_COS_BIT],
                      s_q.cmpc[m][MPWM_CMP_ADD_SIN_BIT],
                      s_q.cmpc[m][MPWM_CMP_DIR_LSB +: 2]}; // R15

        mpwm_meter u_meter (
            .mclk(mclk),
            .rst_n(rst_n),
            .cnt(s_q.cnt),
            .run(s_q.run),
            .ovf(ovf),
            .load(ovf && ten[m]), // R19
            .cfg(cfg),
            .hold_sin(s_q.hold_sin[m]),
            .hold_cos(s_q.hold_cos[m]),
            .port_val(port_val[m]),
            .pins(meter_pins[m])
        );

        property p_ten_clear;
            @(posedge mclk) disable iff (!rst_n)
            ovf && ten[m] && !cmpc_hit[m] |=> !ten[m];
        endproperty
        a_ten_clear: assert property (p_ten_clear) else $error("transfer flag not cleared"); // R12

        property p_ten_set;
            @(posedge mclk) disable iff (!rst_n)
            cmpc_hit[m] && bus.wdata[MPWM_CMP_TEN_BIT] |=> ten[m];
        endproperty
        a_ten_set: assert property (p_ten_set) else $error("transfer request lost"); // R11

        property p_ten_hold;
            @(posedge mclk) disable iff (!rst_n)
            ten[m] && !ovf && !cmpc_hit[m] |=> ten[m];
        endproperty
        a_ten_hold: assert property (p_ten_hold) else $error("pending flag dropped"); // R11

        c_transfer: cover property (@(posedge mclk) disable iff (!rst_n) ovf && ten[m]);
    end

    // Checks
    property p_stop_clears;
        @(posedge mclk) disable iff (!rst_n)
        !s_q.run |=> cnt_now == 8'h00;
    endproperty
    a_stop_clears: assert property (p_stop_clears) else $error("stopped counter not zero"); // R3

    property p_count_step;
        @(posedge mclk) disable iff (!rst_n)
        s_q.run && tick && cnt_now != MPWM_CNT_TOP |=> cnt_now == $past(cnt_now) + 8'h01;
    endproperty
    a_count_step: assert property (p_count_step) else $error("counter step wrong"); // R3

    property p_wrap;
        @(posedge mclk) disable iff (!rst_n)
        ovf |=> cnt_now == MPWM_CNT_WRAP;
    endproperty
    a_wrap: assert property (p_wrap) else $error("counter wrap wrong"); // R3

    property p_hold_between_ticks;
        @(posedge mclk) disable iff (!rst_n)
        s_q.run && !tick ##1 s_q.run |-> cnt_now == $past(cnt_now);
    endproperty
    a_hold_between_ticks: assert property (p_hold_between_ticks) else $error("count off tick"); // R6

    property p_slow_tick;
        @(posedge mclk) disable iff (!rst_n)
        s_q.clksel && tick |=> (!tick || !s_q.clksel) [*7];
    endproperty
    a_slow_tick: assert property (p_slow_tick) else $error("slow clock too fast"); // R7

    property p_fast_tick;
        @(posedge mclk) disable iff (!rst_n)
        !s_q.clksel && tick ##1 !s_q.clksel |-> !tick ##1 (tick || s_q.clksel);
    endproperty
    a_fast_tick: assert property (p_fast_tick) else $error("fast clock period wrong"); // R7

    property p_ctrl_write;
        @(posedge mclk) disable iff (!rst_n)
        bus.wr && bus.addr == MPWM_ADDR_CNT_CTRL
            |=> s_q.run == $past(wdata_now[MPWM_CC_RUN_BIT]);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("run bit not taken"); // R1

    property p_pmc_read;
        @(posedge mclk) disable iff (!rst_n)
        bus.rd && !bus.wr && bus.addr == MPWM_ADDR_PORT_MODE |=> rdata == s_q.meter_port_mode;
    endproperty
    a_pmc_read: assert property (p_pmc_read) else $error("port mode readback wrong"); // R16

    c_overflow: cover property (@(posedge mclk) disable iff (!rst_n) ovf && s_q.clksel);

endmodule : mpwm_ctrl

// *** logic/mpwm_meter.sv ***
/*
 One meter channel: compare slave registers, one-count addition phase, pin routing.
 Assumes counter, overflow and configuration come from the control block on mclk.
*/
`timescale 1ns/1ps
module mpwm_meter
    import mpwm_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [7:0] cnt,
    input wire logic run,
    input wire logic ovf,
    input wire logic load,
    input wire mpwm_meter_cfg_t cfg,
    input wire logic [7:0] hold_sin,
    input wire logic [7:0] hold_cos,
    input wire logic [3:0] port_val,
    output logic [3:0] pins
);

    mpwm_meter_state_t s_q;
    mpwm_meter_state_t s_d;
    logic [8:0] sin_lim;
    logic [8:0] cos_lim;
    logic sin_on;
    logic cos_on;
    logic cos_minus;
    logic [3:0] fill;

    // One extra count on alternate periods
    assign sin_lim = {1'b0, s_q.slave_sin} + {8'h00, cfg.add_sin & s_q.phase}; // R20
    assign cos_lim = {1'b0, s_q.slave_cos} + {8'h00, cfg.add_cos & s_q.phase}; // R20
    assign sin_on = s_q.started && ({1'b0, cnt} <= sin_lim);
    assign cos_on = s_q.started && ({1'b0, cnt} <= cos_lim);
    assign cos_minus = cfg.dir[1] ^ cfg.dir[0];
    assign fill = cfg.half ? port_val : 4'h0; // R22

    always_comb begin
        s_d = s_q;
        if (!run) begin
            s_d.started = 1'b0;
            s_d.phase = 1'b0;
        end else if (ovf) begin
            s_d.started = 1'b1;
            s_d.phase = ~s_q.phase; // R20
        end
        if (load) begin
            s_d.slave_sin = hold_sin; // R19
            s_d.slave_cos = hold_cos; // R19
        end
        s_d.pins[0] = cfg.dir[1] ? fill[0] : sin_on; // R13
        s_d.pins[1] = cfg.dir[1] ? sin_on : fill[1]; // R13
        s_d.pins[2] = cos_minus ? fill[2] : cos_on; // R13
        s_d.pins[3] = cos_minus ? cos_on : fill[3]; // R13
        if (!cfg.en) begin
            s_d.pins = port_val; // R16
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign pins = s_q.pins;

    // Checks
    property p_port_mode;
        @(posedge mclk) disable iff (!rst_n)
        !cfg.en |=> pins == $past(port_val);
    endproperty
    a_port_mode: assert property (p_port_mode) else $error("port mode pins wrong"); // R16

    property p_full_zero;
        @(posedge mclk) disable iff (!rst_n)
        cfg.en && !cfg.half && cfg.dir == 2'b00 |=> !pins[1] && !pins[3];
    endproperty
    a_full_zero: assert property (p_full_zero) else $error("unused pin not low"); // R13

    property p_load;
        @(posedge mclk) disable iff (!rst_n)
        load |=> s_q.slave_sin == $past(hold_sin) && s_q.slave_cos == $past(hold_cos);
    endproperty
    a_load: assert property (p_load) else $error("compare transfer missed"); // R19

    property p_quiet_before_ovf;
        @(posedge mclk) disable iff (!rst_n)
        !s_q.started && cfg.en && !cfg.half ##1 cfg.en && !cfg.half |-> pins == 4'h0;
    endproperty
    a_quiet_before_ovf: assert property (p_quiet_before_ovf) else $error("early pwm"); // R13

    property p_phase;
        @(posedge mclk) disable iff (!rst_n)
        run && ovf |=> s_q.phase != $past(s_q.phase);
    endproperty
    a_phase: assert property (p_phase) else $error("addition phase stuck"); // R20

    c_half: cover property (@(posedge mclk) disable iff (!rst_n) cfg.en && cfg.half && s_q.started);
    c_add: cover property (@(posedge mclk) disable iff (!rst_n) cfg.add_sin && s_q.phase && load);

endmodule : mpwm_meter

// *** logic/mpwm_pkg.sv ***
/*
 Constants, field positions and carrier types of the meter PWM control block.
 Assumes an 8-bit internal register access port on the same clock as the block.
*/
// Contract
// [R1] An 8-bit counter control register governs counter run and count clock.
// [R2] Reset loads zero into counter control; the counter stays stopped.
// [R3] Run bit low halts and clears the counter; high enables counting.
// [R4] Software stops the counter before rewriting counter control.
// [R5] Software writes zeros to counter control bits 0-3, 6 and 7.
// [R6] Counter control holds a field selecting the prescaled count clock.
// [R7] Clock select is one bit choosing between two prescaled clocks.
// [R8] Each meter has an 8-bit compare control for updates and pin direction.
// [R9] Compare control registers are accessed only 8 bits wide.
// [R10] Reset clears every compare control register to zero.
// [R11] Transfer enable is written as a request and read back as pending.
// [R12] Hardware clears transfer enable at the overflow that applies new data.
// [R13] Direction bits route sine and cosine PWM; other pins held at zero.
// [R14] Software writes zeros to compare control bits 5 to 7.
// [R15] Direction bits sit at compare control positions zero and one.
// [R16] An 8-bit port mode register selects PWM or port output per meter.
// [R17] Port mode register is accessed only 8 bits wide.
// [R18] Reset clears port mode: port mode and full bridge everywhere.
// [R19] Transfer enable at bit four moves held compare values at next overflow.
// [R20] Bits two and three enable alternate one-count addition per overflow.
// [R21] Port mode holds half-bridge bits 4-7 and PWM-enable bits 0-3.
// [R22] Half bridge turns otherwise-zero pins into ordinary port outputs.
package mpwm_pkg;

    localparam int MPWM_METERS = 4;

    localparam logic [15:0] MPWM_ADDR_CNT_CTRL = 16'hFF58;
    localparam logic [15:0] MPWM_ADDR_CNT_VALUE = 16'hFF59;
    localparam logic [15:0] MPWM_ADDR_CMP_CTRL = 16'hFF5C;
    localparam logic [15:0] MPWM_ADDR_CMP_VALUE = 16'hFF60;
    localparam logic [15:0] MPWM_ADDR_PORT_MODE = 16'hFF6A;

    localparam int MPWM_CC_CLKSEL_BIT = 4;
    localparam int MPWM_CC_RUN_BIT = 5;

    localparam int MPWM_CMP_DIR_LSB = 0;
    localparam int MPWM_CMP_ADD_SIN_BIT = 2;
    localparam int MPWM_CMP_ADD_COS_BIT = 3;
    localparam int MPWM_CMP_TEN_BIT = 4;
    localparam int MPWM_CMP_WIDTH = 5;

    localparam int MPWM_PM_EN_LSB = 0;
    localparam int MPWM_PM_HALF_LSB = 4;

    localparam logic [7:0] MPWM_CNT_CTRL_RST = 8'h00;
    localparam logic [4:0] MPWM_CMP_CTRL_RST = 5'h00;
    localparam logic [7:0] MPWM_PORT_MODE_RST = 8'h00;
    localparam logic [7:0] MPWM_CMP_VALUE_RST = 8'h00;

    localparam int MPWM_DIV_A_LOG2 = 1;
    localparam int MPWM_DIV_B_LOG2 = 3;
    localparam logic [7:0] MPWM_CNT_TOP = 8'hFF;
    localparam logic [7:0] MPWM_CNT_WRAP = 8'h01;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [7:0] wdata;
    } mpwm_req_t;

    typedef struct packed {
        logic en;
        logic half;
        logic add_cos;
        logic add_sin;
        logic [1:0] dir;
    } mpwm_meter_cfg_t;

    typedef struct packed {
        logic [7:0] slave_sin;
        logic [7:0] slave_cos;
        logic phase;
        logic started;
        logic [3:0] pins;
    } mpwm_meter_state_t;

    typedef struct packed {
        logic [7:0] pre;
        logic run;
        logic clksel;
        logic [7:0] cnt;
        logic [MPWM_METERS-1:0][MPWM_CMP_WIDTH-1:0] cmpc;
        logic [MPWM_METERS-1:0][7:0] hold_sin;
        logic [MPWM_METERS-1:0][7:0] hold_cos;
        logic [7:0] meter_port_mode;
        logic [7:0] rdata;
    } mpwm_top_state_t;

endpackage : mpwm_pkg

// *** tb/meter_pwm_control_regs_test.sv ***
/*
 Self-checking bench of the meter PWM control registers and pin routing.
 Assumes mpwm_ctrl with default prescaler ratios and a coil model on meter 0.
*/
`timescale 1ns/1ps
module meter_pwm_control_regs_test;
    import mpwm_pkg::*;
    logic mclk;
    logic rst_n;
    mpwm_req_t bus;
    logic [MPWM_METERS-1:0][3:0] port_val;
    logic [7:0] rdata;
    logic [MPWM_METERS-1:0][3:0] meter_pins;
    logic coil_clear;
    logic [15:0] sin_on;
    logic [15:0] cos_on;
    logic [7:0] rd_val;
    logic [7:0] pm;
    logic [7:0] regs_m [int];
    int err_total;
    int samples_checked;
    int seed;

    mpwm_ctrl u_dut (
        .mclk(mclk),
        .rst_n(rst_n),
        .bus(bus),
        .port_val(port_val),
        .rdata(rdata),
        .meter_pins(meter_pins)
    );

    mpwm_coil_model u_coil (
        .mclk(mclk),
        .clear(coil_clear),
        .pins(meter_pins[0]),
        .sin_on(sin_on),
        .cos_on(cos_on)
    );

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    task automatic complete_run;
        if (err_total == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Writable bits per address; unmapped places store nothing
    function automatic logic [7:0] wmask(input logic [15:0] a);
        if (a == 16'hFF58) return 8'h30;
        if (a >= 16'hFF5C && a <= 16'hFF5F) return 8'h1F;
        if ((a >= 16'hFF60 && a <= 16'hFF67) || a == 16'hFF6A) return 8'hFF;
        return 8'h00;
    endfunction : wmask

    // Expected pins with sine PWM steady high and cosine PWM steady low
    function automatic logic [3:0] pin_exp(input logic en, input logic half,
                                           input logic [1:0] dir, input logic [3:0] pv);
        logic [3:0] r;
        if (!en) return pv;
        r = half ? pv : 4'h0;
        r[dir[1]] = 1'b1;
        r[(dir == 2'd0 || dir == 2'd3) ? 2 : 3] = 1'b0;
        return r;
    endfunction : pin_exp

    // Byte-wide write of the data as given; the model keeps only its writable bits
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk);
        #1;
        bus.wr = 1'b1;
        bus.addr = a;
        bus.wdata = d;
        @(posedge mclk);
        #1;
        bus.wr = 1'b0;
        regs_m[int'(a)] = d & wmask(a);
    endtask : wr

    task automatic rd(input logic [15:0] a);
        @(posedge mclk);
        #1;
        bus.rd = 1'b1;
        bus.addr = a;
        @(posedge mclk);
        #1;
        bus.rd = 1'b0;
        rd_val = rdata;
    endtask : rd

    task automatic wait_ten(input int m);
        int i;
        for (i = 0; i < 1500; i++) begin
            rd(16'hFF5C + 16'(m));
            if (rd_val[MPWM_CMP_TEN_BIT] === 1'b0) break;
        end
        if (i == 1500) begin
            err_total++;
            complete_run();
        end
        regs_m[16'hFF5C + m][MPWM_CMP_TEN_BIT] = 1'b0;
    endtask : wait_ten

    initial begin
        seed = 32'hfbab_f4ed;
        rst_n = 1'b0;
        bus = '0;
        port_val = '0;
        coil_clear = 1'b1;
        err_total = 0;
        samples_checked = 0;
        repeat (16) @(posedge mclk);
        #1;
        rst_n = 1'b1;
        // Reset values, counter value and unmapped places all read zero
        for (int a = 16'hFF58; a <= 16'hFF6F; a++) begin
            rd(16'(a));
            check(16'(rd_val), 16'h0000);
            regs_m[a] = 8'h00;
        end
        // Random write and readback, one unmapped place among them
        for (int i = 0; i < 30; i++) begin
            logic [15:0] a;
            a = (i % 6 == 5) ? 16'hFF70 : ((i % 6 == 4) ? 16'hFF6A : 16'hFF5C + 16'(i % 6));
            wr(a, 8'($random(seed)) & (a == 16'hFF70 ? 8'hFF : wmask(a)));
            rd(a);
            check(16'(rd_val), 16'(regs_m[int'(a)]));
        end
        wr(16'hFF58, 8'h10);
        rd(16'hFF58);
        check(16'(rd_val), 16'h0010);
        wr(16'hFF58, 8'h00);
        // Sine slaves full scale, cosine slaves zero
        for (int m = 0; m < 4; m++) begin
            wr(16'hFF60 + 16'(2 * m), 8'hFF);
            wr(16'hFF61 + 16'(2 * m), 8'h00);
            wr(16'hFF5C + 16'(m), 8'h10);
        end
        rd(16'hFF5C);
        check(16'(rd_val), 16'h0010);
        wr(16'hFF58, 8'h20);
        for (int m = 0; m < 4; m++) wait_ten(m);
        // Routing through every direction code, bridge kind and pin mode
        for (int k = 0; k < 16; k++) begin
            pm = 8'($random(seed));
            for (int m = 0; m < 4; m++) wr(16'hFF5C + 16'(m), 8'((k + m) % 4));
            wr(16'hFF6A, pm);
            port_val = 16'($random(seed));
            repeat (2) @(posedge mclk);
            #1;
            for (int m = 0; m < 4; m++) begin
                check(16'(meter_pins[m]),
                      16'(pin_exp(pm[m], pm[m + 4], 2'((k + m) % 4), port_val[m])));
            end
        end
        // Alternate extra count on both coils of meter 0
        wr(16'hFF60, 8'h80);
        wr(16'hFF61, 8'h00);
        wr(16'hFF5C, 8'h1C);
        wr(16'hFF6A, 8'h01);
        wait_ten(0);
        for (int p = 0; p < 2; p++) begin
            coil_clear = 1'b1;
            @(posedge mclk);
            #1;
            coil_clear = 1'b0;
            repeat (1020) @(posedge mclk);
            #1;
            check(sin_on, p == 0 ? 16'd514 : 16'd512);
            check(cos_on, p == 0 ? 16'd2 : 16'd0);
            wr(16'hFF5C, 8'h00);
        end
        // Stop clears the counter and silences PWM until the next overflow
        rd(16'hFF59);
        check(16'(rd_val != 8'h00), 16'h0001);
        wr(16'hFF58, 8'h00);
        rd(16'hFF59);
        check(16'(rd_val), 16'h0000);
        repeat (2) @(posedge mclk);
        #1;
        check(16'(meter_pins[0]), 16'h0000);
        // Count rate for each clock select value
        for (int s = 0; s < 2; s++) begin
            wr(16'hFF58, s == 0 ? 8'h20 : 8'h30);
            repeat (80) @(posedge mclk);
            rd(16'hFF59);
            check(16'(s == 0 ? (rd_val inside {[38:44]}) : (rd_val inside {[8:12]})),
                  16'h0001);
            wr(16'hFF58, 8'h00);
        end
        complete_run();
    end
endmodule : meter_pwm_control_regs_test

// *** tb/mpwm_coil_model.sv ***
/*
 Coil load of one meter: counts clock cycles in which each coil carries current.
 Assumes the meter's four registered pin levels on mclk; clear restarts both counts.
*/
`timescale 1ns/1ps
module mpwm_coil_model (
    input wire logic mclk,
    input wire logic clear,
    input wire logic [3:0] pins,
    output logic [15:0] sin_on,
    output logic [15:0] cos_on
);
    // Current flows while the two ends of a coil differ
    always @(posedge mclk) begin
        sin_on <= clear ? 16'h0000 : sin_on + 16'(pins[0] ^ pins[1]);
        cos_on <= clear ? 16'h0000 : cos_on + 16'(pins[2] ^ pins[3]);
    end
endmodule : mpwm_coil_model
